//--- hdl/loop_inc_jump_irq_exec.sv
// Executor for loop, increment, jump, interrupt enable/return and halt opcodes.
// Assumes program memory and register file answer a read while the registered strobe stands.
`timescale 1ns/1ps

module loop_inc_jump_irq_exec #(
  parameter logic [15:0] RESET_PC = loop_exec_pkg::RST_PC
) (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic [11:0] i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [7:0]  o_reg_rdata,
  output logic      [15:0] o_pm_addr,
  output logic             o_pm_rd,
  input  wire logic [7:0]  i_pm_data,
  output logic      [11:0] o_rf_addr,
  output logic      [7:0]  o_rf_wdata,
  output logic             o_rf_wr,
  output logic             o_rf_rd,
  input  wire logic [7:0]  i_rf_data,
  output logic             o_irq_enable,
  output logic             o_halted
);

  // ***********************************************************
  // Elaboration checks and state encoding
  // ***********************************************************
  if (RESET_PC[0] !== 1'b0 && RESET_PC[0] !== 1'b1) begin : g_bad_pc
    $error("RESET_PC must be a known value");
  end

  typedef enum logic [13:0] {
    ST_FETCH  = 14'h0001,
    ST_DECODE = 14'h0002,
    ST_OPND   = 14'h0004,
    ST_JPLO   = 14'h0008,
    ST_PTR    = 14'h0010,
    ST_ALU8   = 14'h0020,
    ST_WHI    = 14'h0040,
    ST_WLO    = 14'h0080,
    ST_WWR    = 14'h0100,
    ST_DJNZ   = 14'h0200,
    ST_IRETF  = 14'h0400,
    ST_IRETH  = 14'h0800,
    ST_IRETL  = 14'h1000,
    ST_HALT   = 14'h2000
  } exec_state_e;

  exec_state_e state;
  logic [15:0] pc;
  logic [7:0]  op;
  logic [7:0]  hi_byte;
  logic [11:0] ea;
  logic [7:0]  flags;
  logic [7:0]  irq_ctl;
  logic [7:0]  reg_ptr;
  logic [7:0]  sp_hi;
  logic [7:0]  sp_lo;

  // ***********************************************************
  // Address formation and arithmetic
  // ***********************************************************
  // Working registers live at {page, group, index}; E0-EF need group E or a pointer
  wire logic [7:0]  op_in     = i_pm_data;
  wire logic [11:0] wreg_op   = {reg_ptr[3:0], reg_ptr[7:4], op_in[7:4]};
  wire logic        escaped   = (op_in[7:4] == loop_exec_pkg::NIB_ESCAPE);
  wire logic [11:0] opnd_addr = escaped ? {reg_ptr[3:0], reg_ptr[7:4], op_in[3:0]}
                                        : {reg_ptr[3:0], op_in};
  wire logic [11:0] ptr_addr  = {reg_ptr[3:0], i_rf_data};  // Pointer value taken as is
  wire logic [11:0] ea_next   = ea + 12'h001;               // Low byte of an even pair
  wire logic [15:0] sp_word   = {sp_hi, sp_lo};
  wire logic [15:0] sp_plus1  = sp_word + 16'h0001;
  wire logic [15:0] sp_plus2  = sp_word + 16'h0002;
  wire logic [7:0]  inc_res   = i_rf_data + 8'h01;
  wire logic [7:0]  dec_res   = i_rf_data - 8'h01;
  wire logic [15:0] word_in   = {hi_byte, i_rf_data};
  wire logic [15:0] word_res  = word_in + 16'h0001;
  // Base is already past the offset byte when the offset arrives
  wire logic [15:0] dj_target = pc + {{8{op_in[7]}}, op_in};
  wire logic        wake      = i_reg_wr && (i_reg_addr == loop_exec_pkg::ADDR_RUN_CTL)
                                && i_reg_wdata[loop_exec_pkg::CTRL_WAKE];
  wire logic        is_djnz   = (op_in[3:0] == loop_exec_pkg::NIB_DJNZ);
  wire logic        is_inc_w  = (op_in[3:0] == loop_exec_pkg::NIB_INC_W);
  wire logic        two_byte  = (op_in == loop_exec_pkg::OP_INC_R)
                                || (op_in == loop_exec_pkg::OP_INC_IND)
                                || (op_in == loop_exec_pkg::OP_INC_WORD)
                                || (op_in == loop_exec_pkg::OP_INC_WORD_IND)
                                || (op_in == loop_exec_pkg::OP_JUMP_DIRECT)
                                || (op_in == loop_exec_pkg::OP_JUMP_PAIR);

  // Flag update shared by byte and word increment: C, D, H pass through
  function automatic logic [7:0] arith_flags(input logic [7:0] old, input logic z,
                                             input logic s, input logic v);
    logic [7:0] f;
    f = old;
    f[loop_exec_pkg::FLAG_Z] = z;
    f[loop_exec_pkg::FLAG_S] = s;
    f[loop_exec_pkg::FLAG_V] = v;
    return f;
  endfunction

  wire logic [7:0] flags_inc8  = arith_flags(flags, inc_res == 8'h00, inc_res[7],
                                             i_rf_data == loop_exec_pkg::BYTE_MAX_POS);
  wire logic [7:0] flags_inc16 = arith_flags(flags, word_res == 16'h0000, word_res[15],
                                             word_in == loop_exec_pkg::WORD_MAX_POS);

  // ***********************************************************
  // Software register port
  // ***********************************************************
  // Read data decode; unmapped addresses return zero
  wire logic [7:0] rd_sel =
    (i_reg_addr == loop_exec_pkg::ADDR_FLAGS)   ? flags   :
    (i_reg_addr == loop_exec_pkg::ADDR_IRQ_CTL) ? irq_ctl :
    (i_reg_addr == loop_exec_pkg::ADDR_SP_HIGH) ? sp_hi   :
    (i_reg_addr == loop_exec_pkg::ADDR_SP_LOW)  ? sp_lo   :
    (i_reg_addr == loop_exec_pkg::ADDR_REG_PTR) ? reg_ptr :
    (i_reg_addr == loop_exec_pkg::ADDR_RUN_CTL) ? {7'h00, o_halted} : 8'h00;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= loop_exec_pkg::RST_BYTE;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rd_sel;
    end
  end

  assign o_irq_enable = irq_ctl[loop_exec_pkg::IRQ_ENABLE];

  // ***********************************************************
  // Sequencer
  // ***********************************************************
  // Software writes land first; an opcode state writing the same register bits in the same cycle overrides those bits
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state      <= ST_FETCH;
      pc         <= RESET_PC;
      op         <= loop_exec_pkg::RST_BYTE;
      hi_byte    <= loop_exec_pkg::RST_BYTE;
      ea         <= 12'h000;
      flags      <= loop_exec_pkg::RST_BYTE;
      irq_ctl    <= loop_exec_pkg::RST_BYTE;
      reg_ptr    <= loop_exec_pkg::RST_BYTE;
      sp_hi      <= loop_exec_pkg::RST_BYTE;
      sp_lo      <= loop_exec_pkg::RST_BYTE;
      o_pm_addr  <= RESET_PC;
      o_pm_rd    <= 1'b0;
      o_rf_addr  <= 12'h000;
      o_rf_wdata <= loop_exec_pkg::RST_BYTE;
      o_rf_wr    <= 1'b0;
      o_rf_rd    <= 1'b0;
      o_halted   <= 1'b0;
    end else begin
      o_pm_rd <= 1'b0;
      o_rf_rd <= 1'b0;
      o_rf_wr <= 1'b0;
      if (i_reg_wr) begin
        case (i_reg_addr)
          loop_exec_pkg::ADDR_FLAGS:   flags   <= i_reg_wdata;
          loop_exec_pkg::ADDR_IRQ_CTL: irq_ctl <= i_reg_wdata;
          loop_exec_pkg::ADDR_SP_HIGH: sp_hi   <= i_reg_wdata;
          loop_exec_pkg::ADDR_SP_LOW:  sp_lo   <= i_reg_wdata;
          loop_exec_pkg::ADDR_REG_PTR: reg_ptr <= i_reg_wdata;
          default: ;
        endcase
      end
      case (state)
        ST_FETCH: begin
          o_pm_addr <= pc;
          o_pm_rd   <= 1'b1;
          pc        <= pc + 16'h0001;
          state     <= ST_DECODE;
        end
        ST_DECODE: begin
          op <= op_in;
          if (op_in == loop_exec_pkg::OP_IRQ_ON) begin
            irq_ctl[loop_exec_pkg::IRQ_ENABLE] <= 1'b1;
            state <= ST_FETCH;
          end else if (op_in == loop_exec_pkg::OP_IRQ_OFF) begin
            irq_ctl[loop_exec_pkg::IRQ_ENABLE] <= 1'b0;
            state <= ST_FETCH;
          end else if (op_in == loop_exec_pkg::OP_HALT) begin
            o_halted <= 1'b1;
            state    <= ST_HALT;
          end else if (op_in == loop_exec_pkg::OP_INT_RETURN) begin
            o_rf_addr <= sp_word[11:0];
            o_rf_rd   <= 1'b1;
            state     <= ST_IRETF;
          end else if (is_inc_w) begin
            ea        <= wreg_op;
            o_rf_addr <= wreg_op;
            o_rf_rd   <= 1'b1;
            state     <= ST_ALU8;
          end else if (is_djnz || two_byte) begin
            // Counter read and offset fetch go out together
            ea        <= wreg_op;
            o_rf_addr <= wreg_op;
            o_rf_rd   <= is_djnz;
            o_pm_addr <= pc;
            o_pm_rd   <= 1'b1;
            pc        <= pc + 16'h0001;
            state     <= is_djnz ? ST_DJNZ : ST_OPND;
          end else begin
            state <= ST_FETCH;  // Other opcodes belong to other units
          end
        end
        ST_OPND: begin
          if (op == loop_exec_pkg::OP_JUMP_DIRECT) begin
            hi_byte   <= op_in;  // High byte comes first
            o_pm_addr <= pc;
            o_pm_rd   <= 1'b1;
            pc        <= pc + 16'h0001;
            state     <= ST_JPLO;
          end else begin
            ea        <= opnd_addr;
            o_rf_addr <= opnd_addr;
            o_rf_rd   <= 1'b1;
            if (op == loop_exec_pkg::OP_INC_R) begin
              state <= ST_ALU8;
            end else if (op == loop_exec_pkg::OP_INC_IND
                         || op == loop_exec_pkg::OP_INC_WORD_IND) begin
              state <= ST_PTR;
            end else begin
              state <= ST_WHI;
            end
          end
        end
        ST_JPLO: begin
          pc    <= {hi_byte, op_in};
          state <= ST_FETCH;
        end
        ST_PTR: begin
          // Even effective address is software's duty, pair low byte is at +1
          ea        <= ptr_addr;
          o_rf_addr <= ptr_addr;
          o_rf_rd   <= 1'b1;
          state     <= (op == loop_exec_pkg::OP_INC_IND) ? ST_ALU8 : ST_WHI;
        end
        ST_ALU8: begin
          o_rf_addr  <= ea;
          o_rf_wdata <= inc_res;
          o_rf_wr    <= 1'b1;
          flags      <= flags_inc8;
          state      <= ST_FETCH;
        end
        ST_WHI: begin
          hi_byte   <= i_rf_data;
          o_rf_addr <= ea_next;
          o_rf_rd   <= 1'b1;
          state     <= ST_WLO;
        end
        ST_WLO: begin
          if (op == loop_exec_pkg::OP_JUMP_PAIR) begin
            pc    <= word_in;
            state <= ST_FETCH;
          end else begin
            o_rf_addr  <= ea_next;
            o_rf_wdata <= word_res[7:0];
            o_rf_wr    <= 1'b1;
            hi_byte    <= word_res[15:8];
            flags      <= flags_inc16;
            state      <= ST_WWR;
          end
        end
        ST_WWR: begin
          o_rf_addr  <= ea;
          o_rf_wdata <= hi_byte;
          o_rf_wr    <= 1'b1;
          state      <= ST_FETCH;
        end
        ST_DJNZ: begin
          o_rf_addr  <= ea;
          o_rf_wdata <= dec_res;
          o_rf_wr    <= 1'b1;
          if (dec_res != 8'h00) begin
            pc <= dj_target;
          end
          state <= ST_FETCH;
        end
        ST_IRETF: begin
          flags     <= i_rf_data;
          {sp_hi, sp_lo} <= sp_plus1;
          o_rf_addr <= sp_plus1[11:0];
          o_rf_rd   <= 1'b1;
          state     <= ST_IRETH;
        end
        ST_IRETH: begin
          hi_byte   <= i_rf_data;
          o_rf_addr <= sp_plus1[11:0];
          o_rf_rd   <= 1'b1;
          state     <= ST_IRETL;
        end
        ST_IRETL: begin
          pc             <= {hi_byte, i_rf_data};
          {sp_hi, sp_lo} <= sp_plus2;
          irq_ctl[loop_exec_pkg::IRQ_ENABLE] <= 1'b1;
          state          <= ST_FETCH;
        end
        ST_HALT: begin
          // No fetch while parked, so a stray memory answer cannot be consumed
          if (wake) begin
            o_halted <= 1'b0;
            state    <= ST_FETCH;
          end
        end
        default: state <= ST_FETCH;
      endcase
    end
  end

  // ***********************************************************
  // Assertions
  // ***********************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  AST_DJNZ_TAKEN: assert property (
    (state == ST_DJNZ && dec_res != 8'h00) |=> (pc == $past(dj_target) && o_rf_wr))
    else $error("loop branch target wrong");
  AST_DJNZ_FALL: assert property (
    (state == ST_DJNZ && dec_res == 8'h00) |=> (pc == $past(pc) && o_rf_wdata == 8'h00))
    else $error("loop fall-through moved PC");
  // Backward reach checked by magnitude, independent of the sign-extension path
  AST_DJNZ_BACK: assert property (
    (state == ST_DJNZ && op_in[7] && dec_res != 8'h00)
      |=> pc == $past(pc) - {8'h00, 8'h00 - $past(op_in)})
    else $error("negative offset reach wrong");
  AST_IRQ_ON: assert property (
    (state == ST_DECODE && op_in == loop_exec_pkg::OP_IRQ_ON) |=> o_irq_enable)
    else $error("enable opcode left bit 7 clear");
  AST_IRQ_OFF: assert property (
    (state == ST_DECODE && op_in == loop_exec_pkg::OP_IRQ_OFF) |=> !o_irq_enable)
    else $error("disable opcode left bit 7 set");
  AST_HALT_ENTRY: assert property (
    (state == ST_DECODE && op_in == loop_exec_pkg::OP_HALT && !i_reg_wr)
      |=> (o_halted && state == ST_HALT && flags == $past(flags)))
    else $error("halt entry wrong");
  AST_HALT_QUIET: assert property (
    (state == ST_HALT && !wake) |=> (!o_pm_rd && !o_rf_wr && !o_rf_rd && state == ST_HALT))
    else $error("activity while halted");
  AST_INC_FLAGS: assert property (
    (state == ST_ALU8 && !i_reg_wr) |=> (flags[loop_exec_pkg::FLAG_Z] == (o_rf_wdata == 8'h00)
      && flags[loop_exec_pkg::FLAG_C] == $past(flags[loop_exec_pkg::FLAG_C])))
    else $error("byte increment flags wrong");
  AST_RETURN_SEQ: assert property (
    (state == ST_IRETF && !i_reg_wr) ##1 !i_reg_wr ##1 !i_reg_wr
      |=> (o_irq_enable && {sp_hi, sp_lo} == $past(sp_word, 3) + 16'd3))
    else $error("interrupt return stack or enable wrong");
  AST_JP_DIRECT: assert property (
    (state == ST_JPLO && !i_reg_wr) |=> (pc == {$past(hi_byte), $past(op_in)}
      && flags == $past(flags)))
    else $error("direct jump target wrong");

  COV_DJNZ_LOOP: cover property (state == ST_DJNZ && dec_res != 8'h00);
  COV_INT_RETURN: cover property (state == ST_IRETL);
  COV_HALT_WAKE: cover property (state == ST_HALT && wake);
  COV_INC_WORD: cover property (state == ST_WWR);

endmodule

//--- hdl/loop_exec_pkg.sv
// Shared constants for the loop, increment, jump and interrupt-return executor.
// Assumes a 12-bit register file and a 16-bit program memory space outside the block.
package loop_exec_pkg;

  // ***********************************************************
  // Opcodes
  // ***********************************************************
  localparam logic [7:0] OP_IRQ_ON       = 8'h9f;
  localparam logic [7:0] OP_IRQ_OFF      = 8'h8f;
  localparam logic [7:0] OP_HALT         = 8'h7f;
  localparam logic [7:0] OP_INC_R        = 8'h20;
  localparam logic [7:0] OP_INC_IND      = 8'h21;
  localparam logic [7:0] OP_INC_WORD     = 8'ha0;
  localparam logic [7:0] OP_INC_WORD_IND = 8'ha1;
  localparam logic [7:0] OP_INT_RETURN   = 8'hbf;
  localparam logic [7:0] OP_JUMP_DIRECT  = 8'h8d;
  localparam logic [7:0] OP_JUMP_PAIR    = 8'hc4;
  localparam logic [3:0] NIB_DJNZ        = 4'ha;  // Low nibble of the loop opcodes
  localparam logic [3:0] NIB_INC_W       = 4'he;  // Low nibble of working-register increments
  localparam logic [3:0] NIB_ESCAPE      = 4'he;  // Operand high nibble naming a working register

  // ***********************************************************
  // Flag bit positions and control bits
  // ***********************************************************
  localparam int FLAG_C       = 7;
  localparam int FLAG_Z       = 6;
  localparam int FLAG_S       = 5;
  localparam int FLAG_V       = 4;
  localparam int IRQ_ENABLE   = 7;
  localparam int CTRL_WAKE    = 0;
  localparam int STAT_HALTED  = 0;
  localparam logic [7:0]  BYTE_MAX_POS = 8'h7f;
  localparam logic [15:0] WORD_MAX_POS = 16'h7fff;

  // ***********************************************************
  // Register offsets and reset values
  // ***********************************************************
  localparam logic [11:0] ADDR_FLAGS    = 12'h0fc;
  localparam logic [11:0] ADDR_IRQ_CTL  = 12'hfcf;
  localparam logic [11:0] ADDR_SP_HIGH  = 12'hffe;
  localparam logic [11:0] ADDR_SP_LOW   = 12'hfff;
  localparam logic [11:0] ADDR_REG_PTR  = 12'hffd;
  localparam logic [11:0] ADDR_RUN_CTL  = 12'hff0;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [15:0] RST_PC        = 16'h0000;

endpackage

//--- verif/loop_exec_mem_model.sv
// Program memory and register file storage beside the executor.
// Assumes reads are answered while the registered strobe stands, never read and write at once.
`timescale 1ns/1ps
module loop_exec_mem_model (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_pm_addr,
  input  wire logic        i_pm_rd,
  output logic      [7:0]  o_pm_data,
  input  wire logic [11:0] i_rf_addr,
  input  wire logic [7:0]  i_rf_wdata,
  input  wire logic        i_rf_wr,
  input  wire logic        i_rf_rd,
  output logic      [7:0]  o_rf_data
);
  logic [7:0] pm [0:65535];
  logic [7:0] rf [0:4095];

  // Erased bytes are unused opcodes, so a stray fetch runs as a no-op
  initial begin
    for (int i = 0; i < 65536; i++) pm[i] = 8'hff;
    for (int i = 0; i < 4096; i++) rf[i] = 8'h00;
  end

  // Data stand only while the strobe does; otherwise the inverse shows so stale reads fail
  assign o_pm_data = i_pm_rd ? pm[i_pm_addr] : ~pm[i_pm_addr];
  assign o_rf_data = i_rf_rd ? rf[i_rf_addr] : ~rf[i_rf_addr];

  // Writes land at the edge that samples the strobe
  always @(posedge i_clk) begin
    if (i_rf_wr) begin
      rf[i_rf_addr] <= i_rf_wdata;
    end
  end
endmodule

//--- verif/test_loop_inc_jump_irq_exec.sv
// Self-checking bench: a program with halts as checkpoints runs on the executor.
// Assumes the storage model and a working-register page of 00 after reset.
`timescale 1ns/1ps
module test_loop_inc_jump_irq_exec;
  logic        i_clk, i_resetn, i_reg_wr, i_reg_rd, o_pm_rd, o_rf_wr, o_rf_rd;
  logic        o_irq_enable, o_halted;
  logic [11:0] i_reg_addr, o_rf_addr;
  logic [7:0]  i_reg_wdata, o_reg_rdata, i_pm_data, o_rf_wdata, i_rf_data;
  logic [15:0] o_pm_addr;
  int          failures, checks, cycles, loop_fetches;

  loop_inc_jump_irq_exec dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_pm_addr(o_pm_addr), .o_pm_rd(o_pm_rd),
    .i_pm_data(i_pm_data), .o_rf_addr(o_rf_addr), .o_rf_wdata(o_rf_wdata),
    .o_rf_wr(o_rf_wr), .o_rf_rd(o_rf_rd), .i_rf_data(i_rf_data),
    .o_irq_enable(o_irq_enable), .o_halted(o_halted));
  loop_exec_mem_model mdl (.i_clk(i_clk), .i_pm_addr(o_pm_addr), .i_pm_rd(o_pm_rd),
    .o_pm_data(i_pm_data), .i_rf_addr(o_rf_addr), .i_rf_wdata(o_rf_wdata),
    .i_rf_wr(o_rf_wr), .i_rf_rd(o_rf_rd), .o_rf_data(i_rf_data));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Cycle ceiling cuts a hang short; fetches of the loop opcode at 0005 are counted
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (o_pm_rd === 1'b1 && o_pm_addr === 16'h0005) loop_fetches <= loop_fetches + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      finish_test();
    end
  end

  // ****************************
  // Shared tasks
  // ****************************
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_clk);
    i_reg_wr    <= 1'b0;
  endtask

  // Read data appear in the cycle after the strobe and hold until the next read, so sample there and once more
  task automatic check_reg(input logic [11:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_clk);
    i_reg_rd   <= 1'b0;
    #1;
    check_val({8'h00, o_reg_rdata}, {8'h00, exp}, "register read");
    @(posedge i_clk);
    #1;
    check_val({8'h00, o_reg_rdata}, {8'h00, exp}, "read data held");
  endtask

  task automatic check_rf(input logic [11:0] a, input logic [7:0] exp);
    check_val({8'h00, mdl.rf[a]}, {8'h00, exp}, "register file byte");
  endtask

  task automatic wait_halt(input logic [15:0] pc);
    int n;
    int busy;
    n = 0;
    busy = 0;
    while (o_halted !== 1'b1 && n < 400) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check_val({15'h0, o_halted}, 16'h0001, "halt entered");
    check_val(o_pm_addr, pc, "halt address");
    repeat (8) begin
      @(posedge i_clk);
      #1;
      if (o_pm_rd !== 1'b0) busy++;
    end
    check_val(busy[15:0], 16'h0000, "fetch while halted");
  endtask

  task automatic wake();
    int n;
    n = 0;
    reg_write(12'hff0, 8'h01);
    while (o_halted !== 1'b0 && n < 10) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check_val({15'h0, o_halted}, 16'h0000, "wake");
  endtask

  // Bytes are taken from the top of the value downwards
  task automatic put_seq(input logic [15:0] a, input logic [39:0] b, input int n);
    for (int i = 0; i < n; i++) mdl.pm[a + 16'(i)] = b[39 - 8 * i -: 8];
  endtask

  // ****************************
  // Scenarios
  // ****************************
  task automatic test_reset_values();
    wait_halt(16'h0000);
    check_reg(loop_exec_pkg::ADDR_FLAGS, 8'h00);
    check_reg(loop_exec_pkg::ADDR_IRQ_CTL, 8'h00);
    check_reg(loop_exec_pkg::ADDR_SP_HIGH, 8'h00);
    check_reg(loop_exec_pkg::ADDR_SP_LOW, 8'h00);
    check_reg(12'h123, 8'h00);
    check_reg(loop_exec_pkg::ADDR_RUN_CTL, 8'h01);
    wake();
  endtask

  task automatic test_irq_ops();
    wait_halt(16'h0002);
    check_val({15'h0, o_irq_enable}, 16'h0001, "enable op");
    check_reg(12'hfcf, 8'h80);
    wake();
    wait_halt(16'h0004);
    check_val({15'h0, o_irq_enable}, 16'h0000, "disable op");
    check_reg(12'hfcf, 8'h00);
    wake();
  endtask

  // Backward loop by -2 three times, then a forward branch of +127
  task automatic test_loop();
    wait_halt(16'h0088);
    check_val(loop_fetches[15:0], 16'h0003, "loop passes");
    check_rf(12'h006, 8'h00);
    check_rf(12'h005, 8'h01);
    reg_write(loop_exec_pkg::ADDR_FLAGS, 8'h80);
    wake();
  endtask

  task automatic test_inc_byte();
    wait_halt(16'h008b);
    check_rf(12'h030, 8'h80);
    check_reg(12'h0fc, 8'hb0);
    wake();
    wait_halt(16'h008d);
    check_rf(12'h00e, 8'h00);
    check_reg(12'h0fc, 8'hc0);
    wake();
  endtask

  task automatic test_inc_word();
    wait_halt(16'h0090);
    check_rf(12'h040, 8'h80);
    check_rf(12'h041, 8'h00);
    check_reg(12'h0fc, 8'hb0);
    wake();
  endtask

  task automatic test_jumps();
    wait_halt(16'h2000);
    check_reg(12'h0fc, 8'hb0);
    reg_write(12'hffe, 8'h00);
    reg_write(12'hfff, 8'h45);
    wake();
  endtask

  task automatic test_irq_return();
    wait_halt(16'h3000);
    check_reg(12'h0fc, 8'hc0);
    check_reg(12'hfff, 8'h48);
    check_reg(12'hffe, 8'h00);
    check_reg(12'hfcf, 8'h80);
    check_val({15'h0, o_irq_enable}, 16'h0001, "return enable");
  endtask

  // Indirect byte and direct word increments with working group 1
  task automatic test_inc_forms();
    reg_write(loop_exec_pkg::ADDR_REG_PTR, 8'h10);
    wake();
    wait_halt(16'h3005);
    check_reg(loop_exec_pkg::ADDR_REG_PTR, 8'h10);
    check_rf(12'h033, 8'h01);
    check_rf(12'h040, 8'h80);
    check_rf(12'h041, 8'h01);
    check_reg(12'h0fc, 8'ha0);
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Halts split the program into checkpoints; pairs sit at even addresses
  initial begin
    i_resetn = 1'b0;
    i_reg_addr = 12'h000;
    i_reg_wdata = 8'h00;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    failures = 0;
    checks = 0;
    cycles = 0;
    loop_fetches = 0;
    #1;
    put_seq(16'h0000, 40'h7f9f7f8f7f, 5);
    put_seq(16'h0005, 40'h6afe5a7f00, 4);
    put_seq(16'h0088, 40'h7f20307fee, 5);
    put_seq(16'h008d, 40'h7fa1e27f8d, 5);
    put_seq(16'h0092, 40'h1234000000, 2);
    put_seq(16'h1234, 40'hc4e8000000, 2);
    put_seq(16'h2000, 40'h7fbf000000, 2);
    put_seq(16'h3000, 40'h7f21e5a040, 5);
    put_seq(16'h3005, 40'h7f00000000, 1);
    mdl.rf[12'h002] = 8'h40;
    mdl.rf[12'h005] = 8'h02;
    mdl.rf[12'h006] = 8'h03;
    mdl.rf[12'h008] = 8'h20;
    mdl.rf[12'h00e] = 8'hff;
    mdl.rf[12'h030] = 8'h7f;
    mdl.rf[12'h040] = 8'h7f;
    mdl.rf[12'h041] = 8'hff;
    mdl.rf[12'h045] = 8'hc0;
    mdl.rf[12'h046] = 8'h30;
    mdl.rf[12'h015] = 8'h33;
    repeat (6) @(posedge i_clk);
    i_resetn <= 1'b1;
    test_reset_values();
    test_irq_ops();
    test_loop();
    test_inc_byte();
    test_inc_word();
    test_jumps();
    test_irq_return();
    test_inc_forms();
    finish_test();
  end
endmodule
